// ### odrc_pkg.sv
// Shared constants and types for the output double-rate register cell
package odrc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned   ADDR_W      = 12;
  localparam int unsigned   DATA_W      = 32;
  localparam logic [11:0]   CTRL_OFF    = 12'h000;
  localparam logic [11:0]   STATUS_OFF  = 12'h004;
  localparam logic [11:0]   PAIRS_OFF   = 12'h008;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int unsigned   CTRL_SAME_EDGE  = 0;
  localparam int unsigned   CTRL_ASYNC      = 1;
  localparam int unsigned   CTRL_DATA_DDR   = 2;
  localparam int unsigned   CTRL_TRI_DDR    = 3;
  localparam int unsigned   CTRL_DATA_FORCE = 4;
  localparam int unsigned   CTRL_TRI_FORCE  = 5;
  localparam int unsigned   CTRL_W          = 6;
  localparam logic [5:0]    CTRL_RESET      = 6'h0C;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int unsigned   STAT_RISE       = 0;
  localparam int unsigned   STAT_FALL       = 1;
  localparam int unsigned   STAT_EXTRA      = 2;
  localparam int unsigned   STAT_TRI_RISE   = 3;
  localparam int unsigned   STAT_TRI_FALL   = 4;
  localparam int unsigned   STAT_TRI_EXTRA  = 5;
  localparam int unsigned   STAT_FORWARD    = 6;
  localparam int unsigned   STAT_INIT       = 7;
  localparam int unsigned   STAT_W          = 8;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic {
    ODRC_OPPOSITE_EDGE,
    ODRC_SAME_EDGE
  } odrc_edge_t;

  typedef enum logic {
    ODRC_SYNC,
    ODRC_ASYNC
  } odrc_set_reset_type_t;

endpackage : odrc_pkg

// ### odrc_stage.sv
// One storage element of the cell with set, reset, enable and power-up value
`timescale 1ns/1ps
module odrc_stage #(
  parameter logic INIT_VALUE = 1'b0
) (
  input  wire logic clk,
  input  wire logic presetn,
  input  wire logic async_mode,
  input  wire logic reset_in,
  input  wire logic set_in,
  input  wire logic enable,
  input  wire logic d,
  output logic      q
);

  // ----------------------------------------------------------------
  // Set and reset steering
  // ----------------------------------------------------------------
  // Reset beats set whichever type is chosen
  wire logic async_clr = async_mode & reset_in;
  wire logic async_set = async_mode & set_in & ~reset_in;
  wire logic sync_clr  = ~async_mode & reset_in;
  wire logic sync_set  = ~async_mode & set_in;

  always_ff @(posedge clk or negedge presetn or posedge async_clr or posedge async_set) begin
    if (!presetn) begin
      q <= INIT_VALUE;
    end else if (async_clr) begin
      q <= 1'b0;
    end else if (async_set) begin
      q <= 1'b1;
    end else if (sync_clr) begin
      q <= 1'b0;
    end else if (sync_set) begin
      q <= 1'b1;
    end else if (enable) begin
      q <= d;
    end
  end

endmodule : odrc_stage

// ### odrc_cell.sv
// Output double-rate register cell with its APB control registers
//
// Contract
// - Same-edge mode adds rising stage before falling.
// - Same-edge still alternates both bits each period.
// - Rise low, fall high forwards the clock.
// - Low enable holds the output registers.
// - Active-high reset clears the output registers.
// - Active-high set forces the registers to one.
// - Edge mode selects opposite or same edge.
// - Power-up output level is zero or one.
// - Set and reset are sync or async.
// - Single-rate: enabled rising sample reaches output.
// - Sync reset clears single-rate data register.
// - Double-rate: first bit rising, second falling.
// - Sync reset clears rise then fall register.
// - Single-rate tristate sampled rising, high floats pad.
// - Sync reset clears single-rate tristate register.
// - Double-rate tristate: first rising, second falling.
// - Sync reset clears tristate rise then fall.
// - One clock, inverted locally, selects the multiplexer.
// - Enables active high, default asserted; force bits reset to 0, so neither enable is forced.
`timescale 1ns/1ps
module odrc_cell #(
  parameter logic        INIT_VALUE = 1'b0,
  parameter int unsigned PAIRS_W    = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rise_data_in,
  input  wire logic        fall_data_in,
  input  wire logic        rise_tristate_in,
  input  wire logic        fall_tristate_in,
  input  wire logic        data_path_enable,
  input  wire logic        tristate_path_enable,
  input  wire logic        reset_in,
  input  wire logic        set_in,
  output logic             data_to_pad,
  output logic             tristate_to_pad
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PAIRS_W < 1 || PAIRS_W > 32) begin : g_bad_pairs_w
    $error("PAIRS_W must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
    addr_is = (addr == off);
  endfunction : addr_is

  // DDR multiplexer: clock high shows the rising stage
  function automatic logic ddr_pick(input logic clk_level, input logic rise_q, input logic fall_q);
    ddr_pick = clk_level ? rise_q : fall_q;
  endfunction : ddr_pick

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [odrc_pkg::CTRL_W-1:0] ctrl;
  logic [PAIRS_W-1:0]          pairs;
  logic [PAIRS_W-1:0]          next_pairs;

  wire logic hit_ctrl   = addr_is(paddr, odrc_pkg::CTRL_OFF);
  wire logic hit_status = addr_is(paddr, odrc_pkg::STATUS_OFF);
  wire logic hit_pairs  = addr_is(paddr, odrc_pkg::PAIRS_OFF);
  wire logic hit_any    = hit_ctrl | hit_status | hit_pairs;
  wire logic setup_ph   = psel & ~penable;
  wire logic access_ph  = psel & penable;
  wire logic wr_ctrl    = access_ph & pwrite & hit_ctrl & pstrb[0];
  wire logic wr_pairs   = access_ph & pwrite & hit_pairs;

  // Zero-wait slave: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_any;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= odrc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[odrc_pkg::CTRL_W-1:0];
    end
  end

  // Mode changes are meant to be static; changing them mid-stream may glitch the pad
  wire odrc_pkg::odrc_edge_t   edge_mode = ctrl[odrc_pkg::CTRL_SAME_EDGE] ?
                                           odrc_pkg::ODRC_SAME_EDGE : odrc_pkg::ODRC_OPPOSITE_EDGE;
  wire odrc_pkg::odrc_set_reset_type_t sr_type   = ctrl[odrc_pkg::CTRL_ASYNC] ?
                                           odrc_pkg::ODRC_ASYNC : odrc_pkg::ODRC_SYNC;
  wire logic same_edge = (edge_mode == odrc_pkg::ODRC_SAME_EDGE);
  wire logic async_sr  = (sr_type == odrc_pkg::ODRC_ASYNC);
  wire logic data_ddr  = ctrl[odrc_pkg::CTRL_DATA_DDR];
  wire logic tri_ddr   = ctrl[odrc_pkg::CTRL_TRI_DDR];

  // Force bits stand in for an enable pin left unconnected
  wire logic data_en = data_path_enable | ctrl[odrc_pkg::CTRL_DATA_FORCE];
  wire logic tri_en  = tristate_path_enable | ctrl[odrc_pkg::CTRL_TRI_FORCE];

  // ----------------------------------------------------------------
  // Local clock inversion
  // ----------------------------------------------------------------
  wire logic clk_inv = ~pclk;

  // ----------------------------------------------------------------
  // Data path registers
  // ----------------------------------------------------------------
  logic data_rise_q;
  logic data_extra_q;
  logic data_fall_q;

  odrc_stage #(
    .INIT_VALUE (INIT_VALUE)
  ) u_data_rise (
    .clk        (pclk),
    .presetn    (presetn),
    .async_mode (async_sr),
    .reset_in   (reset_in),
    .set_in     (set_in),
    .enable     (data_en),
    .d          (rise_data_in),
    .q          (data_rise_q)
  );

  // Holds the falling bit sampled on the rising edge
  odrc_stage #(
    .INIT_VALUE (INIT_VALUE)
  ) u_data_extra (
    .clk        (pclk),
    .presetn    (presetn),
    .async_mode (async_sr),
    .reset_in   (reset_in),
    .set_in     (set_in),
    .enable     (data_en),
    .d          (fall_data_in),
    .q          (data_extra_q)
  );

  wire logic data_fall_d = same_edge ? data_extra_q : fall_data_in;

  // Enable is shared with the rising stages, so it must be stable at both edges
  odrc_stage #(
    .INIT_VALUE (INIT_VALUE)
  ) u_data_fall (
    .clk        (clk_inv),
    .presetn    (presetn),
    .async_mode (async_sr),
    .reset_in   (reset_in),
    .set_in     (set_in),
    .enable     (data_en),
    .d          (data_fall_d),
    .q          (data_fall_q)
  );

  // ----------------------------------------------------------------
  // Tristate path registers
  // ----------------------------------------------------------------
  logic tri_rise_q;
  logic tri_extra_q;
  logic tri_fall_q;

  odrc_stage #(
    .INIT_VALUE (INIT_VALUE)
  ) u_tri_rise (
    .clk        (pclk),
    .presetn    (presetn),
    .async_mode (async_sr),
    .reset_in   (reset_in),
    .set_in     (set_in),
    .enable     (tri_en),
    .d          (rise_tristate_in),
    .q          (tri_rise_q)
  );

  odrc_stage #(
    .INIT_VALUE (INIT_VALUE)
  ) u_tri_extra (
    .clk        (pclk),
    .presetn    (presetn),
    .async_mode (async_sr),
    .reset_in   (reset_in),
    .set_in     (set_in),
    .enable     (tri_en),
    .d          (fall_tristate_in),
    .q          (tri_extra_q)
  );

  wire logic tri_fall_d = same_edge ? tri_extra_q : fall_tristate_in;

  odrc_stage #(
    .INIT_VALUE (INIT_VALUE)
  ) u_tri_fall (
    .clk        (clk_inv),
    .presetn    (presetn),
    .async_mode (async_sr),
    .reset_in   (reset_in),
    .set_in     (set_in),
    .enable     (tri_en),
    .d          (tri_fall_d),
    .q          (tri_fall_q)
  );

  // ----------------------------------------------------------------
  // Double-rate multiplexers
  // ----------------------------------------------------------------
  // Select comes from the clock itself; each input changes on the same edge that selects it
  wire logic data_ddr_out = ddr_pick(pclk, data_rise_q, data_fall_q);
  wire logic tri_ddr_out  = ddr_pick(pclk, tri_rise_q, tri_fall_q);

  assign data_to_pad     = data_ddr ? data_ddr_out : data_rise_q;
  assign tristate_to_pad = tri_ddr ? tri_ddr_out : tri_rise_q;

  // ----------------------------------------------------------------
  // Clock forwarding detection
  // ----------------------------------------------------------------
  // Stored pattern rise=0 fall=1 makes the pad an inverted copy of the clock
  wire logic forward_seen = data_ddr & ~data_rise_q & data_fall_q;

  // ----------------------------------------------------------------
  // Pair counter
  // ----------------------------------------------------------------
  // Counts enabled rising edges without reset or set; an edge in the clearing cycle still counts
  wire logic pair_event = data_en & ~reset_in & ~set_in;

  always_comb begin
    next_pairs = pairs;
    if (wr_pairs) begin
      next_pairs = '0;
    end
    if (pair_event) begin
      next_pairs = (wr_pairs ? PAIRS_W'(0) : pairs) + PAIRS_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pairs <= '0;
    end else begin
      pairs <= next_pairs;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [odrc_pkg::STAT_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[odrc_pkg::STAT_RISE]      = data_rise_q;
    status_word[odrc_pkg::STAT_FALL]      = data_fall_q;
    status_word[odrc_pkg::STAT_EXTRA]     = data_extra_q;
    status_word[odrc_pkg::STAT_TRI_RISE]  = tri_rise_q;
    status_word[odrc_pkg::STAT_TRI_FALL]  = tri_fall_q;
    status_word[odrc_pkg::STAT_TRI_EXTRA] = tri_extra_q;
    status_word[odrc_pkg::STAT_FORWARD]   = forward_seen;
    status_word[odrc_pkg::STAT_INIT]      = INIT_VALUE;
  end

  wire logic [31:0] ctrl_rd   = {{(32 - odrc_pkg::CTRL_W){1'b0}}, ctrl};
  wire logic [31:0] status_rd = {{(32 - odrc_pkg::STAT_W){1'b0}}, status_word};
  wire logic [31:0] pairs_rd  = 32'(pairs);
  wire logic [31:0] rd_mux    = hit_ctrl   ? ctrl_rd :
                                hit_status ? status_rd :
                                hit_pairs  ? pairs_rd : 32'h0000_0000;

  // Read data is caught in the setup cycle, ready for the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule : odrc_cell

// ### odrc_cell_note_end.sv
// Spare file that holds no logic

// ### odrc_cell_sva.sv
// Checker for the output double-rate register cell
`timescale 1ns/1ps
module odrc_cell_sva #(
  parameter logic INIT_VALUE = 1'b0
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        rise_data_in,
  input wire logic        fall_data_in,
  input wire logic        rise_tristate_in,
  input wire logic        fall_tristate_in,
  input wire logic        data_path_enable,
  input wire logic        tristate_path_enable,
  input wire logic        reset_in,
  input wire logic        set_in,
  input wire logic        data_to_pad,
  input wire logic        tristate_to_pad
);
  // ----
  // Shadow of control word and stages
  // ----
  logic [5:0] ctrl;
  logic       hr, hx, hf, ht, htx, htf;
  wire        acc     = psel && penable;
  wire        den     = data_path_enable | ctrl[4];
  wire        ten     = tristate_path_enable | ctrl[5];
  wire        next_hr = reset_in ? 1'b0 : set_in ? 1'b1 : den ? rise_data_in : hr;
  wire        next_hx = reset_in ? 1'b0 : set_in ? 1'b1 : den ? fall_data_in : hx;
  wire        next_ht = reset_in ? 1'b0 : set_in ? 1'b1 : ten ? rise_tristate_in : ht;
  wire        next_hf = reset_in ? 1'b0 : set_in ? 1'b1 : den ? (ctrl[0] ? hx : fall_data_in) : hf;
  wire        next_htx = reset_in ? 1'b0 : set_in ? 1'b1 : ten ? fall_tristate_in : htx;
  wire        next_htf = reset_in ? 1'b0 : set_in ? 1'b1 : ten ? (ctrl[0] ? htx : fall_tristate_in) : htf;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 6'h0C;
      hr   <= INIT_VALUE;
      hx   <= INIT_VALUE;
      ht   <= INIT_VALUE;
      htx  <= INIT_VALUE;
    end else begin
      if (acc && pwrite && pready && paddr == 12'h000 && pstrb[0]) ctrl <= pwdata[5:0];
      hr <= next_hr;
      hx <= next_hx;
      ht <= next_ht;
      htx <= next_htx;
    end
  end
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf  <= INIT_VALUE;
      htf <= INIT_VALUE;
    end else begin
      hf  <= next_hf;
      htf <= next_htf;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Properties
  // ----
  a_rise_half: assert property (@(negedge pclk) disable iff (!presetn)
    !ctrl[1] |-> data_to_pad == hr) else $error("high half data wrong");
  a_fall_half: assert property (!ctrl[1] && ctrl[2] |-> data_to_pad == hf)
    else $error("low half data wrong");
  a_single_rate: assert property (!ctrl[1] && !ctrl[2] |-> data_to_pad == hr)
    else $error("single-rate data wrong");
  a_tri_rise: assert property (@(negedge pclk) disable iff (!presetn)
    !ctrl[1] |-> tristate_to_pad == ht) else $error("high half tristate wrong");
  a_tri_fall: assert property (!ctrl[1] && ctrl[3] |-> tristate_to_pad == htf)
    else $error("low half tristate wrong");
  a_sync_clear: assert property (!ctrl[1] && reset_in ##1 reset_in |->
    !data_to_pad && !tristate_to_pad) else $error("sync reset not cleared");
  a_async_clear: assert property (ctrl[1] && reset_in |-> !data_to_pad && !tristate_to_pad)
    else $error("async reset not at once");
  a_async_set: assert property (ctrl[1] && set_in && !reset_in |-> data_to_pad && tristate_to_pad)
    else $error("async set not at once");
  a_ctrl_read: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[5:0] == ctrl)
    else $error("control readback wrong");
  a_init_status: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata[7] == INIT_VALUE)
    else $error("power-up level readback wrong");
  c_same_edge: cover property (ctrl[0] && ctrl[2] && data_path_enable);
  c_async_rst: cover property (ctrl[1] && reset_in);
  c_forward: cover property (ctrl[2] && !rise_data_in && fall_data_in);
endmodule : odrc_cell_sva

bind odrc_cell odrc_cell_sva #(.INIT_VALUE(INIT_VALUE)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .rise_data_in(rise_data_in), .fall_data_in(fall_data_in), .rise_tristate_in(rise_tristate_in),
  .fall_tristate_in(fall_tristate_in),
  .data_path_enable(data_path_enable), .tristate_path_enable(tristate_path_enable),
  .reset_in(reset_in), .set_in(set_in), .data_to_pad(data_to_pad), .tristate_to_pad(tristate_to_pad));

// ### odrc_pad_model.sv
// Pad-side receiver that samples each clock half
`timescale 1ns/1ps
module odrc_pad_model (
  input  wire logic       pclk,
  input  wire logic       data_to_pad,
  input  wire logic       tristate_to_pad,
  output logic      [1:0] hi,
  output logic      [1:0] lo
);
  // Sampling 4 ns after each edge, late in the 5 ns half, stays clear of the edge-driven multiplexer
  always @(posedge pclk) begin
    #4;
    hi = {tristate_to_pad, data_to_pad};
  end
  always @(negedge pclk) begin
    #4;
    lo = {tristate_to_pad, data_to_pad};
  end
endmodule : odrc_pad_model

// ### odrc_cell_tb.sv
// Self-checking bench for the output double-rate register cell
`timescale 1ns/1ps
module odrc_cell_tb;
  localparam logic INIT = 1'b1;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_in, set_in, chk, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  r, f, e, hi, lo, m_r, m_x, m_f;
  logic [5:0]  ctrl;
  logic [5:0]  modes [4] = '{6'h0C, 6'h0D, 6'h00, 6'h39};
  int          fail_count, compares, cyc;
  wire  [1:0]  en = e | {ctrl[5], ctrl[4]};
  wire         dq, tq;
  odrc_cell #(.INIT_VALUE(INIT)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rise_data_in(r[0]), .fall_data_in(f[0]), .rise_tristate_in(r[1]),
    .fall_tristate_in(f[1]), .data_path_enable(e[0]), .tristate_path_enable(e[1]),
    .reset_in(rst_in), .set_in(set_in), .data_to_pad(dq), .tristate_to_pad(tq));
  odrc_pad_model PAD (.pclk(pclk), .data_to_pad(dq), .tristate_to_pad(tq), .hi(hi), .lo(lo));
  // ----
  // Expectation and reporting
  // ----
  function automatic logic [1:0] upd(logic [1:0] old, logic [1:0] d);
    if (rst_in) return 2'b00;
    if (set_in) return 2'b11;
    return (en & d) | (~en & old);
  endfunction : upd
  function automatic logic [1:0] exp_lo(logic [5:0] c);
    return ({c[3], c[2]} & m_f) | (~{c[3], c[2]} & m_r);
  endfunction : exp_lo
  task automatic check(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready is high; the cycle timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a == 12'h000 && pstrb[0]) ctrl <= wd[5:0];
  endtask : apb
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (presetn && chk) begin
      check(hi === m_r, "high half");
      check(lo === exp_lo(ctrl), "low half");
    end
    if (presetn) m_x = upd(m_x, f);
    if (presetn) m_r = upd(m_r, r);
  end
  always @(negedge pclk) if (presetn) m_f = upd(m_f, ctrl[0] ? m_x : f);
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hF; r = 0; f = 0; e = 2'b00; rst_in = 0; set_in = 0; chk = 0;
    m_r = {2{INIT}}; m_x = {2{INIT}}; m_f = {2{INIT}}; ctrl = 6'h0C;
    fail_count = 0; compares = 0; cyc = 0;
    void'($urandom(32));
    repeat (4) @(posedge pclk);
    check({tq, dq} === {2{INIT}}, "power-up level");
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd[5:0] === 6'h0C, "control reset");
    apb(1'b0, 12'h004, 32'h0);
    check(rd[7:0] === {INIT, 1'b0, {6{INIT}}}, "status reset");
    apb(1'b0, 12'h010, 32'h0);
    check(err === 1'b1, "unmapped read");
    chk = 1;
    foreach (modes[i]) begin
      apb(1'b1, 12'h000, {26'h0, modes[i]});
      repeat (60) begin
        @(posedge pclk);
        r <= 2'($urandom);
        f <= 2'($urandom);
        e <= ($urandom % 4 == 0) ? 2'($urandom) : 2'b11;
        rst_in <= ($urandom % 12 == 0);
        set_in <= ($urandom % 12 == 1);
      end
    end
    apb(1'b1, 12'h000, 32'h0C);
    @(posedge pclk);
    r <= 2'b00; f <= 2'b11; e <= 2'b11; rst_in <= 1'b0; set_in <= 1'b0;
    repeat (4) @(posedge pclk);
    check(hi === 2'b00 && lo === 2'b11, "forwarded clock");
    apb(1'b0, 12'h004, 32'h0);
    check(rd[6] === 1'b1, "forward pattern");
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    // Clearing edge counts once, one more edge before capture
    check(rd === 32'h0000_0002, "pair count");
    pstrb <= 4'hE;
    apb(1'b1, 12'h000, 32'h0000_003F);
    pstrb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    check(rd[5:0] === 6'h0C, "masked control write");
    rst_in <= 1'b1;
    repeat (3) @(posedge pclk);
    rst_in <= 1'b0;
    chk = 0;
    apb(1'b1, 12'h000, 32'h0E);
    @(posedge pclk);
    set_in <= 1'b1;
    #2 check({tq, dq} === 2'b11, "async set");
    @(posedge pclk);
    rst_in <= 1'b1;
    #2 check({tq, dq} === 2'b00, "async reset over set");
    repeat (2) @(posedge pclk);
    report_and_stop();
  end
endmodule : odrc_cell_tb
